// ===== mbt_top.sv
// Boundary-scan test port of a memory device: instruction, bypass, id, chain.
// Assumes test clock, mode and data arrive asynchronously, far slower than MCLK_I.
// What this block does
// - Registers: instruction 8, bypass 1, id 32, chain 113
// - All-ones code puts bypass in the path
// - Extest and sample capture ring, select chain
// - Id code loads id value, selects it
// - Clamp selects bypass, outputs drive chain values
// - High-Z selects bypass, floats every output
// - Shift-DR after capture shifts chain out
// - Id fields: revision, device, vendor
// - Id bit zero always reads one
// - Unused ball cells read back zero
// - Id code current after power-up and reset state
// - New instruction acts only at update-IR
// - Sample snapshots ball levels in capture-DR
`timescale 1ns/1ps
`default_nettype none
module mbt_top
	import mbt_pkg::*;
#(
	// Arbitrary neutral identity values
	parameter logic [3:0]  ID_REVISION = 4'h0,
	parameter logic [15:0] ID_DEVICE   = 16'h0000,
	parameter logic [10:0] ID_VENDOR   = 11'h000
)
(
	input  wire logic         MCLK_I,
	input  wire logic         RESET_I,
	input  wire logic         TCK_I,
	input  wire logic         TMS_I,
	input  wire logic         TDI_I,
	output logic              TDO_O,
	output logic              TDO_OE_O,
	input  wire logic [112:0] RING_I,
	output logic      [112:0] RING_DRIVE_O,
	output logic              RING_DRIVE_EN_O,
	output logic              OUT_HIGHZ_O
);
	localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_DEVICE, ID_VENDOR, 1'h1};

	mbt_tap_if tap ();

	// Two-stage synchronisers; stage three of the clock only for edge finding
	logic         tck_s1_q;
	logic         tck_s2_q;
	logic         tck_s3_q;
	logic         tms_s1_q;
	logic         tms_s2_q;
	logic         tdi_s1_q;
	logic         tdi_s2_q;
	logic [112:0] ring_s1_q;
	logic [112:0] ring_s2_q;
	logic         rise;
	logic         fall;

	always_ff @(posedge MCLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			tck_s1_q  <= 1'h0;
			tck_s2_q  <= 1'h0;
			tck_s3_q  <= 1'h0;
			tms_s1_q  <= 1'h1;
			tms_s2_q  <= 1'h1;
			tdi_s1_q  <= 1'h0;
			tdi_s2_q  <= 1'h0;
			ring_s1_q <= '0;
			ring_s2_q <= '0;
		end
		else
		begin
			tck_s1_q  <= TCK_I;
			tck_s2_q  <= tck_s1_q;
			tck_s3_q  <= tck_s2_q;
			tms_s1_q  <= TMS_I;
			tms_s2_q  <= tms_s1_q;
			tdi_s1_q  <= TDI_I;
			tdi_s2_q  <= tdi_s1_q;
			ring_s1_q <= RING_I;
			ring_s2_q <= ring_s1_q;
		end
	end

	// Mode and data share the clock's latency, so they are sampled at its rise
	assign rise     = tck_s2_q & ~tck_s3_q;
	assign fall     = ~tck_s2_q & tck_s3_q;
	assign tap.step = rise;
	assign tap.tms  = tms_s2_q;

	mbt_tap_fsm u_fsm (
		.MCLK_I  (MCLK_I),
		.RESET_I (RESET_I),
		.tap     (tap)
	);

	// Scan state
	logic [7:0]   ir_sh_q;
	logic [7:0]   ir_sh_d;
	logic [7:0]   ir_q;
	logic [7:0]   ir_d;
	logic         byp_q;
	logic         byp_d;
	logic [31:0]  id_q;
	logic [31:0]  id_d;
	logic [112:0] bsr_q;
	logic [112:0] bsr_d;
	logic [112:0] upd_q;
	logic [112:0] upd_d;
	logic         tdo_q;
	logic         tdo_d;
	logic         oe_q;
	logic         oe_d;
	logic         drv_q;
	logic         drv_d;
	logic         hz_q;
	logic         hz_d;
	mbt_dr_e      sel;
	logic         dr_out;

	assign sel = dr_sel(ir_q);

	always_comb
	begin
		case (sel)
			DR_BSR:  dr_out = bsr_q[0];
			DR_ID:   dr_out = id_q[0];
			default: dr_out = byp_q;
		endcase
	end

	always_comb
	begin
		ir_sh_d = ir_sh_q;
		ir_d    = ir_q;
		byp_d   = byp_q;
		id_d    = id_q;
		bsr_d   = bsr_q;
		upd_d   = upd_q;
		tdo_d   = tdo_q;
		oe_d    = oe_q;
		if (rise)
		begin
			case (tap.st)
				S_CAP_IR: ir_sh_d = IR_CAPTURE;
				S_SH_IR:  ir_sh_d = {tdi_s2_q, ir_sh_q[7:1]};
				S_UPD_IR: ir_d = ir_sh_q;
				S_CAP_DR:
				begin
					case (sel)
						DR_BSR:  bsr_d = ring_s2_q & BSR_USED_MASK;
						DR_ID:   id_d = ID_VALUE;
						default: byp_d = 1'h0;
					endcase
				end
				S_SH_DR:
				begin
					case (sel)
						// No mask here, or preload data could never pass the unused cell
						DR_BSR:  bsr_d = {tdi_s2_q, bsr_q[112:1]};
						DR_ID:   id_d = {tdi_s2_q, id_q[31:1]};
						default: byp_d = tdi_s2_q;
					endcase
				end
				S_UPD_DR:
				begin
					// Unused position has no ball, so it never drives
					if (sel == DR_BSR)
						upd_d = bsr_q & BSR_USED_MASK;
				end
				default: ;
			endcase
		end
		// Held while in reset state, not only on an edge
		if (tap.st == S_TLR)
			ir_d = C_IDCODE;
		if (fall)
		begin
			tdo_d = (tap.st == S_SH_IR) ? ir_sh_q[0] : dr_out;
			oe_d  = (tap.st == S_SH_IR) || (tap.st == S_SH_DR);
		end
		drv_d = (ir_d == C_EXTEST) || (ir_d == C_CLAMP);
		hz_d  = (ir_d == C_HIGHZ);
	end

	always_ff @(posedge MCLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ir_sh_q <= IR_CAPTURE;
			ir_q    <= C_IDCODE;
			byp_q   <= 1'h0;
			id_q    <= ID_VALUE;
			bsr_q   <= '0;
			upd_q   <= '0;
			tdo_q   <= 1'h0;
			oe_q    <= 1'h0;
			drv_q   <= 1'h0;
			hz_q    <= 1'h0;
		end
		else
		begin
			ir_sh_q <= ir_sh_d;
			ir_q    <= ir_d;
			byp_q   <= byp_d;
			id_q    <= id_d;
			bsr_q   <= bsr_d;
			upd_q   <= upd_d;
			tdo_q   <= tdo_d;
			oe_q    <= oe_d;
			drv_q   <= drv_d;
			hz_q    <= hz_d;
		end
	end

	assign TDO_O           = tdo_q;
	assign TDO_OE_O        = oe_q;
	assign RING_DRIVE_O    = upd_q;
	// High-Z outranks any drive request
	assign RING_DRIVE_EN_O = drv_q & ~hz_q;
	assign OUT_HIGHZ_O     = hz_q;

	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (RESET_I);

	a_bypass_path: assert property (
		(fall && tap.st == S_SH_DR && ir_q == C_BYPASS) |=> (TDO_O == $past(byp_q) && TDO_OE_O))
		else $error("bypass bit not on serial output");

	a_chain_path: assert property (
		(fall && tap.st == S_SH_DR && (ir_q == C_EXTEST || ir_q == C_SAMPLE))
		|=> (TDO_O == $past(bsr_q[0])))
		else $error("chain cell one not on serial output");

	a_id_load: assert property (
		(rise && tap.st == S_CAP_DR && ir_q == C_IDCODE) |=> (id_q == ID_VALUE))
		else $error("id value not captured");

	a_clamp_drive: assert property (
		(ir_q == C_CLAMP) |-> (RING_DRIVE_EN_O && !OUT_HIGHZ_O && sel == DR_BYPASS))
		else $error("clamp does not drive chain values");

	a_highz_float: assert property (
		(ir_q == C_HIGHZ) |-> (OUT_HIGHZ_O && !RING_DRIVE_EN_O))
		else $error("high-z does not float outputs");

	a_chain_shift: assert property (
		(rise && tap.st == S_SH_DR && sel == DR_BSR)
		|=> (bsr_q == {$past(tdi_s2_q), $past(bsr_q[112:1])}))
		else $error("chain does not shift toward output");

	a_id_fields: assert property (
		(rise && tap.st == S_CAP_DR && ir_q == C_IDCODE)
		|=> (id_q[31:ID_REV_LSB] == ID_REVISION
			&& id_q[ID_REV_LSB-1:ID_DEV_LSB] == ID_DEVICE
			&& id_q[ID_DEV_LSB-1:ID_VEN_LSB] == ID_VENDOR))
		else $error("id fields misplaced");

	a_id_present: assert property (
		(fall && tap.st == S_SH_DR && ir_q == C_IDCODE && $past(tap.st, 9) == S_CAP_DR)
		|=> TDO_O)
		else $error("id bit zero not one");

	a_unused_zero: assert property (
		(rise && tap.st == S_CAP_DR && sel == DR_BSR)
		|=> ((bsr_q & ~BSR_USED_MASK) == '0))
		else $error("unused cell holds one");

	a_tlr_idcode: assert property (
		(tap.st == S_TLR) |=> (ir_q == C_IDCODE))
		else $error("reset state leaves wrong instruction");

	a_ir_update: assert property (
		(tap.st == S_SH_IR) |=> (ir_q == $past(ir_q)))
		else $error("instruction changed during shift");

	a_ir_commit: assert property (
		(rise && tap.st == S_UPD_IR) |=> (ir_q == $past(ir_sh_q)))
		else $error("instruction not taken at update");

	a_sample_snap: assert property (
		(rise && tap.st == S_CAP_DR && ir_q == C_SAMPLE)
		|=> (bsr_q == ($past(ring_s2_q) & BSR_USED_MASK)))
		else $error("sample snapshot wrong");

	a_tdo_on_fall: assert property (
		(!fall && !$rose(TDO_O) && !$fell(TDO_O)) or fall or $past(fall))
		else $error("serial output moved without a fall");

	a_oe_in_shift: assert property (
		(fall && (tap.st == S_SH_DR || tap.st == S_SH_IR)) |=> TDO_OE_O)
		else $error("serial output not enabled in shift");

	a_bypass_capture: assert property (
		(rise && tap.st == S_CAP_DR && sel == DR_BYPASS) |=> !byp_q)
		else $error("bypass bit not cleared at capture");

	a_drive_latch: assert property (
		(rise && tap.st == S_UPD_DR && sel == DR_BSR)
		|=> (RING_DRIVE_O == ($past(bsr_q) & BSR_USED_MASK)))
		else $error("update latch does not hold chain");

endmodule // mbt_top
`default_nettype wire

// ===== mbt_pkg.sv
// Package for the memory boundary-scan test port: codes, sizes, states.
// Assumes one system clock samples the slow test clock from outside.
`default_nettype none
package mbt_pkg;
	localparam int IR_LEN  = 8;
	localparam int ID_LEN  = 32;
	localparam int BSR_LEN = 113;

	localparam logic [7:0] C_EXTEST  = 8'h00;
	localparam logic [7:0] C_IDCODE  = 8'h21;
	localparam logic [7:0] C_SAMPLE  = 8'h05;
	localparam logic [7:0] C_CLAMP   = 8'h07;
	localparam logic [7:0] C_HIGHZ   = 8'h03;
	localparam logic [7:0] C_BYPASS  = 8'hFF;
	// Fixed pattern loaded in capture-IR
	localparam logic [7:0] IR_CAPTURE = 8'h01;

	// Id field positions
	localparam int ID_REV_LSB = 28;
	localparam int ID_DEV_LSB = 12;
	localparam int ID_VEN_LSB = 1;

	// Cells of unused balls read zero; positions are one-based minus one
	localparam logic [112:0] BSR_USED_MASK = {1'h0, 112'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF};

	typedef enum logic [3:0] {
		S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
		S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
	} mbt_state_e;

	typedef enum logic [1:0] {DR_BYPASS, DR_ID, DR_BSR} mbt_dr_e;

	// Reserved codes fall back to the one-bit path
	function automatic mbt_dr_e dr_sel(input logic [7:0] ir);
		if ((ir == C_EXTEST) || (ir == C_SAMPLE))
			return DR_BSR;
		if (ir == C_IDCODE)
			return DR_ID;
		return DR_BYPASS;
	endfunction
endpackage
`default_nettype wire

// ===== mbt_tap_if.sv
// Link between the scan datapath and its sixteen-state controller.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface mbt_tap_if;
	import mbt_pkg::*;
	logic       step;
	logic       tms;
	mbt_state_e st;
	modport fsm  (input step, input tms, output st);
	modport user (output step, output tms, input st);
endinterface
`default_nettype wire

// ===== mbt_tap_fsm.sv
// Test access port state controller, advanced once per test-clock rise.
// Assumes step marks a synchronised rising edge and tms is its sample.
`timescale 1ns/1ps
`default_nettype none
module mbt_tap_fsm
	import mbt_pkg::*;
(
	input  wire logic MCLK_I,
	input  wire logic RESET_I,
	mbt_tap_if.fsm    tap
);
	mbt_state_e st_q;
	mbt_state_e st_d;

	always_comb
	begin
		st_d = st_q;
		if (tap.step)
		begin
			case (st_q)
				S_TLR:    st_d = tap.tms ? S_TLR    : S_RTI;
				S_RTI:    st_d = tap.tms ? S_SEL_DR : S_RTI;
				S_SEL_DR: st_d = tap.tms ? S_SEL_IR : S_CAP_DR;
				S_CAP_DR: st_d = tap.tms ? S_EX1_DR : S_SH_DR;
				S_SH_DR:  st_d = tap.tms ? S_EX1_DR : S_SH_DR;
				S_EX1_DR: st_d = tap.tms ? S_UPD_DR : S_PA_DR;
				S_PA_DR:  st_d = tap.tms ? S_EX2_DR : S_PA_DR;
				S_EX2_DR: st_d = tap.tms ? S_UPD_DR : S_SH_DR;
				S_UPD_DR: st_d = tap.tms ? S_SEL_DR : S_RTI;
				S_SEL_IR: st_d = tap.tms ? S_TLR    : S_CAP_IR;
				S_CAP_IR: st_d = tap.tms ? S_EX1_IR : S_SH_IR;
				S_SH_IR:  st_d = tap.tms ? S_EX1_IR : S_SH_IR;
				S_EX1_IR: st_d = tap.tms ? S_UPD_IR : S_PA_IR;
				S_PA_IR:  st_d = tap.tms ? S_EX2_IR : S_PA_IR;
				S_EX2_IR: st_d = tap.tms ? S_UPD_IR : S_SH_IR;
				S_UPD_IR: st_d = tap.tms ? S_SEL_DR : S_RTI;
				default:  st_d = S_TLR;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			st_q <= S_TLR;
		else
			st_q <= st_d;
	end

	assign tap.st = st_q;
endmodule // mbt_tap_fsm
`default_nettype wire

// ===== mbt_ctl_model.sv
// Test controller model: drives test clock, mode and data, samples serial out.
// Assumes the port synchronises these lines to its own faster system clock.
`timescale 1ns/1ps
`default_nettype none
module mbt_ctl_model
(
	output logic      TCK_O,
	output logic      TMS_O,
	output logic      TDI_O,
	input  wire logic TDO_I,
	input  wire logic TDO_OE_I
);
	// Clock idles low between frames
	initial
	begin
		TCK_O = 1'b0;
		TMS_O = 1'b1;
		TDI_O = 1'b0;
	end
	// Change while low, sample late in high phase: out only moves after a fall
	task automatic step(input logic m, input logic d, output logic q);
		TMS_O = m;
		TDI_O = d;
		#160 TCK_O = 1'b1;
		// Undriven line reads inverted, so a missing enable cannot pass
		#150 q = TDO_OE_I ? TDO_I : ~TDO_I;
		#10 TCK_O = 1'b0;
	endtask
	// Mode sequence LSB first; data line toggles as it carries nothing here
	task automatic walk(input logic [7:0] ms, input int n);
		logic q;
		for (int i = 0; i < n; i++)
			step(ms[i], ~TDI_O, q);
	endtask
	// From a shift state: n bits LSB first, exit, update, idle
	task automatic shift(input logic [112:0] din, input int n, output logic [112:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
		walk(8'h01, 2);
	endtask
	// Only defined codes are ever loaded; ring is static so no cell is ignored
	task automatic load_ir(input logic [7:0] code, output logic [7:0] cap);
		logic [112:0] q;
		walk(8'h03, 4);
		shift({105'h0, code}, 8, q);
		cap = q[7:0];
	endtask
	task automatic read_dr(input logic [112:0] din, input int n, output logic [112:0] dout);
		walk(8'h01, 3);
		shift(din, n, dout);
	endtask
endmodule // mbt_ctl_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the boundary-scan port, controller model at the far side.
// Assumes the design package and the port files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mbt_pkg::*;
	logic         mclk, rst, tck, tms, tdi, tdo, tdo_oe, drv_en, hiz;
	logic [112:0] ring, drv, q;
	logic [7:0]   cap;
	int           n_mismatch = 0;
	int           checks = 0;
	localparam logic [112:0] ID_EXP = {81'h0, 4'hA, 16'h5A3C, 11'h2B5, 1'b1};
	localparam logic [112:0] DIN    = 113'({4{32'h1E2D_3C4B}});
	mbt_top #(.ID_REVISION(4'hA), .ID_DEVICE(16'h5A3C), .ID_VENDOR(11'h2B5)) dut (
		.MCLK_I(mclk), .RESET_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
		.TDO_O(tdo), .TDO_OE_O(tdo_oe), .RING_I(ring), .RING_DRIVE_O(drv),
		.RING_DRIVE_EN_O(drv_en), .OUT_HIGHZ_O(hiz));
	mbt_ctl_model ctl (.TCK_O(tck), .TMS_O(tms), .TDI_O(tdi), .TDO_I(tdo), .TDO_OE_I(tdo_oe));
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic cmp(input logic [112:0] got, input logic [112:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_idcode();
		ctl.read_dr('0, 32, q);
		cmp(q, ID_EXP, "id word");
	endtask
	task automatic t_bypass_modes();
		logic [7:0] codes [3];
		logic [1:0] ctl_exp [3];
		codes = '{C_BYPASS, C_CLAMP, C_HIGHZ};
		ctl_exp = '{2'b00, 2'b10, 2'b01};
		for (int i = 0; i < 3; i++)
		begin
			ctl.load_ir(codes[i], cap);
			cmp({105'h0, cap}, {105'h0, IR_CAPTURE}, "ir capture");
			cmp({111'h0, drv_en, hiz}, {111'h0, ctl_exp[i]}, "drive controls");
			ctl.read_dr(113'h96, 8, q);
			cmp(q, 113'h2C, "one-bit path");
		end
	endtask
	task automatic t_scan();
		@(posedge mclk);
		#1 ring = 113'({4{32'hA5C3_96E1}});
		ctl.load_ir(C_SAMPLE, cap);
		ctl.read_dr(DIN, 113, q);
		cmp(q, ring & BSR_USED_MASK, "sample capture");
		cmp(drv, DIN & BSR_USED_MASK, "preload latch");
		cmp({112'h0, drv_en}, 113'h0, "sample drives nothing");
		@(posedge mclk);
		#1 ring = ~ring;
		ctl.load_ir(C_EXTEST, cap);
		cmp({112'h0, drv_en}, 113'h1, "extest drives");
		ctl.read_dr(~DIN, 113, q);
		cmp(q, ring & BSR_USED_MASK, "extest capture");
		cmp(drv, ~DIN & BSR_USED_MASK, "extest latch");
	endtask
	task automatic t_reset_state();
		ctl.load_ir(C_HIGHZ, cap);
		ctl.walk(8'h1F, 5);
		ctl.walk(8'h00, 1);
		cmp({111'h0, drv_en, hiz}, 113'h0, "controls after reset state");
		t_idcode();
	endtask
	// Each step is a fixed 320 ns, so only this limit guards a hang
	initial
	begin
		#1000000;
		n_mismatch++;
		conclude();
	end
	initial
	begin
		rst = 1'b1;
		ring = '0;
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		cmp({108'h0, |drv, tdo, tdo_oe, drv_en, hiz}, 113'h0, "reset outputs");
		ctl.walk(8'h00, 1);
		t_idcode();
		t_bypass_modes();
		t_scan();
		t_reset_state();
		conclude();
	end
endmodule // testbench
`default_nettype wire
